// *** design/ddr2_ctl_end.sv ***
// Controller end: register port, command checks and data phases
// Overview of operation
// - Read waits CL-1 plus half burst plus transfer
// - Write data needs transfer time into array
// - Gapless writes every half burst clocks
// - Seamless writes to any activated bank
// - Interrupt write bursts only at length eight
// - Only a write may cut a burst
// - Interrupting write exactly two clocks later
// - Interrupting write may target any bank
// - Never interrupt an auto-precharge write
// - Auto-precharge write may interrupt a burst
// - Spacing counts from programmed burst length
// - All banks idle before self refresh
// - Termination off before entry, back after delay
// - Exit delays before read and other commands
// - Frequent clock-enable toggling keeps timing intact
// - Read latency AL+CL, write latency one less
//
// Added by the designer: the strobed register port and the register offsets.
`default_nettype none
module ddr2_ctl_end
	import ddr2_link_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic [REG_A_W-1:0] REG_ADDR,
	input wire logic [PAIR_W-1:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [PAIR_W-1:0] REG_RDATA,
	ddr2_link_if.ctl LINK
);
	typedef struct packed {
		logic [PAIR_W-1:0] rdout;
		logic [ADDR_W-1:0] addr;
		logic bl8;
		logic [2:0] cl;
		logic [2:0] al;
		logic [2:0] wr;
		logic odt_req;
		logic pd;
		logic [3:0][PAIR_W-1:0] wdata;
		logic [3:0][PAIR_W-1:0] rdata;
		logic refused;
		logic sr;
		logic [BANKS-1:0] open;
		cmd_t cmd;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] addr_o;
		logic cke;
		logic odt;
		logic [DLY-1:0] wline;
		logic [DLY-1:0] rline;
		logic wact;
		logic [1:0] wbeat;
		logic ract;
		logic [1:0] rbeat;
		logic [PAIR_W-1:0] dq;
		logic dq_oe_n;
		logic [2:0] since_wr;
		logic last_ap;
		logic [CNT_W-1:0] wtr;
		logic [CNT_W-1:0] xsnr;
		logic [CNT_W-1:0] xsrd;
		logic [CNT_W-1:0] aofd;
	} ctl_t;
	ctl_t r;
	ctl_t next_r;
	logic [3:0] code;
	logic [BANK_W-1:0] b;
	logic ap;
	logic ok;
	logic quiet;
	logic calm;
	logic wr_ok;
	logic [3:0] wl;
	logic [3:0] rl;
	logic [2:0] hb;
	logic [1:0] last;
	logic [1:0] wb;
	logic [1:0] rb;
	logic [BANKS-1:0] tload;
	logic [TMR_W-1:0] tval;
	logic [BANKS-1:0] idle;
	function automatic logic [CNT_W-1:0] dec(logic [CNT_W-1:0] x);
		return (x == '0) ? x : x - 1'b1;
	endfunction
	// Per-bank write recovery timers
	for (genvar g = 0; g < BANKS; g++) begin : g_tmr
		ddr2_countdown #(.W(TMR_W)) u_tmr (
			.clk(CORE_CLK),
			.nrst(NRST),
			.load(tload[g]),
			.value(tval),
			.idle(idle[g])
		);
	end
	always_comb begin
		next_r = r;
		wl = write_latency(r.al, r.cl);
		rl = read_latency(r.al, r.cl);
		hb = half_burst(r.bl8);
		last = r.bl8 ? 2'h3 : 2'h1;
		code = REG_WDATA[CMD_BANK_LSB-1:0];
		b = REG_WDATA[CMD_BANK_LSB +: BANK_W];
		ap = REG_WDATA[CMD_AP_BIT];
		tload = '0;
		tval = 5'(wl) + 5'(hb) + 5'(r.wr) - 5'h1;
		// Clock enable high at issue; it drops with the command only at self refresh entry
		quiet = !r.sr && r.cke && !r.pd;
		calm = quiet && r.xsnr == '0 && r.open == '0 && &idle;
		// Gapless at half burst, or cut at two clocks
		wr_ok = r.since_wr >= hb ||
			(r.bl8 && r.since_wr == 3'h2 && !r.last_ap);
		case (code)
			4'(CMD_NOP): ok = 1'b1;
			4'(CMD_ACT): ok = quiet && r.xsnr == '0 && !r.open[b] &&
				idle[b];
			// Read held off by write-to-read and exit delays
			4'(CMD_RD): ok = quiet && r.xsrd == '0 && r.open[b] &&
				r.wtr == '0;
			4'(CMD_WR): ok = quiet && r.xsnr == '0 && r.open[b] &&
				wr_ok;
			4'(CMD_PRE): ok = quiet && r.xsnr == '0 && r.since_wr >= hb &&
				(r.addr[AP_BIT] ? &idle : idle[b]);
			4'(CMD_REF), 4'(CMD_MRS), 4'(CMD_EMRS): ok = calm;
			SW_SRE: ok = calm && !r.odt && r.aofd == '0;
			SW_SRX: ok = r.sr;
			default: ok = 1'b0;
		endcase
		next_r.cmd = CMD_NOP;
		next_r.since_wr = (r.since_wr == SINCE_SAT) ? r.since_wr :
			r.since_wr + 3'h1;
		next_r.wtr = dec(r.wtr);
		next_r.xsnr = dec(r.xsnr);
		next_r.xsrd = dec(r.xsrd);
		next_r.aofd = r.odt ? CNT_W'(AOFD_CYC - 1) : dec(r.aofd);
		next_r.wline = {r.wline[DLY-2:0], 1'b0};
		next_r.rline = {r.rline[DLY-2:0], 1'b0};
		next_r.cke = !r.sr && !r.pd;
		if (REG_WR && REG_ADDR == REG_CMD) begin
			if (!ok) begin
				next_r.refused = 1'b1;
			end else begin
				next_r.bank = b;
				next_r.addr_o = r.addr;
				if (code < 4'h8) begin
					next_r.cmd = cmd_t'(code[2:0]);
				end
				unique case (code)
					4'(CMD_ACT): next_r.open[b] = 1'b1;
					4'(CMD_PRE): begin
						if (r.addr[AP_BIT]) begin
							next_r.open = '0;
						end else begin
							next_r.open[b] = 1'b0;
						end
					end
					4'(CMD_RD): begin
						next_r.addr_o[AP_BIT] = ap;
						next_r.rline[0] = 1'b1;
						next_r.open[b] = r.open[b] && !ap;
					end
					4'(CMD_WR): begin
						next_r.addr_o[AP_BIT] = ap;
						next_r.wline[0] = 1'b1;
						next_r.open[b] = r.open[b] && !ap;
						next_r.since_wr = 3'h1;
						next_r.last_ap = ap;
						tload[b] = 1'b1;
						// Read spacing from programmed burst
						next_r.wtr = CNT_W'(r.cl) + CNT_W'(hb) +
							CNT_W'(WTR_CYC) - CNT_W'(2);
					end
					4'(CMD_MRS): begin
						next_r.addr_o = '0;
						next_r.addr_o[MRS_BL_LSB +: 3] = r.bl8 ? BL8_CODE :
							BL4_CODE;
						next_r.addr_o[MRS_CL_LSB +: 3] = r.cl;
						next_r.addr_o[MRS_WR_LSB +: 3] = r.wr - 3'h1;
					end
					4'(CMD_EMRS): begin
						next_r.addr_o = '0;
						next_r.addr_o[EMRS_AL_LSB +: 3] = r.al;
					end
					SW_SRE: begin
						next_r.cmd = CMD_REF;
						next_r.cke = 1'b0;
						next_r.sr = 1'b1;
					end
					SW_SRX: begin
						next_r.cke = !r.pd;
						next_r.sr = 1'b0;
						next_r.xsnr = CNT_W'(XSNR_CYC - 1);
						next_r.xsrd = CNT_W'(XSRD_CYC - 1);
					end
					default: ;
				endcase
			end
		end
		// Termination stays off in self refresh and until exit delay
		next_r.odt = r.odt_req && !next_r.sr && r.xsrd == '0;
		// Launch one clock early so the first pair lands at write latency
		wb = r.wline[wl-4'h1] ? 2'h0 : r.wbeat;
		next_r.dq_oe_n = 1'b1;
		if (r.wline[wl-4'h1] || r.wact) begin
			next_r.dq = r.wdata[wb];
			next_r.dq_oe_n = 1'b0;
			next_r.wbeat = wb + 2'h1;
			next_r.wact = (wb != last);
		end
		// First read pair stands read latency after the command
		rb = r.rline[rl] ? 2'h0 : r.rbeat;
		if (r.rline[rl] || r.ract) begin
			next_r.rdata[rb] = LINK.dq;
			next_r.rbeat = rb + 2'h1;
			next_r.ract = (rb != last);
		end
		if (REG_WR) begin
			unique case (REG_ADDR)
				ddr2_link_pkg::REG_ADDR: begin
					next_r.addr = REG_WDATA[ADDR_W-1:0];
				end
				REG_MODE: begin
					next_r.bl8 = REG_WDATA[MODE_BL8_BIT];
					next_r.cl = REG_WDATA[MODE_CL_LSB +: 3];
					next_r.al = REG_WDATA[MODE_AL_LSB +: 3];
					next_r.wr = REG_WDATA[MODE_WR_LSB +: 3];
				end
				REG_CTRL: begin
					next_r.odt_req = REG_WDATA[CTRL_ODT_BIT];
					next_r.pd = REG_WDATA[CTRL_PD_BIT];
				end
				REG_STATUS: begin
					// A refusal in the same cycle wins over the clear
					if (REG_WDATA[ST_REFUSED] &&
						!(REG_WR && REG_ADDR == REG_CMD && !ok)) begin
						next_r.refused = 1'b0;
					end
				end
				default: begin
					if (REG_ADDR[3:2] == REG_WDATA0[3:2]) begin
						next_r.wdata[REG_ADDR[1:0]] = REG_WDATA;
					end
				end
			endcase
		end
		next_r.rdout = '0;
		if (REG_RD) begin
			unique case (REG_ADDR)
				ddr2_link_pkg::REG_ADDR: next_r.rdout = PAIR_W'(r.addr);
				REG_MODE: begin
					next_r.rdout[MODE_BL8_BIT] = r.bl8;
					next_r.rdout[MODE_CL_LSB +: 3] = r.cl;
					next_r.rdout[MODE_AL_LSB +: 3] = r.al;
					next_r.rdout[MODE_WR_LSB +: 3] = r.wr;
				end
				REG_CTRL: begin
					next_r.rdout[CTRL_ODT_BIT] = r.odt_req;
					next_r.rdout[CTRL_PD_BIT] = r.pd;
				end
				REG_STATUS: begin
					next_r.rdout[ST_REFUSED] = r.refused;
					next_r.rdout[ST_SR] = r.sr;
					next_r.rdout[ST_CKE] = r.cke;
					next_r.rdout[ST_ODT] = r.odt;
					next_r.rdout[ST_OPEN_LSB +: BANKS] = r.open;
				end
				default: begin
					if (REG_ADDR[3:2] == REG_WDATA0[3:2]) begin
						next_r.rdout = r.wdata[REG_ADDR[1:0]];
					end else if (REG_ADDR[3:2] == REG_RDATA0[3:2]) begin
						next_r.rdout = r.rdata[REG_ADDR[1:0]];
					end
				end
			endcase
		end
	end
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			r <= '0;
			r.cl <= CL_RST;
			r.al <= AL_RST;
			r.wr <= WR_RST;
			r.cke <= 1'b1;
			r.dq_oe_n <= 1'b1;
			r.since_wr <= SINCE_SAT;
		end else begin
			r <= next_r;
		end
	end
	assign REG_RDATA = r.rdout;
	assign LINK.cke = r.cke;
	assign LINK.odt = r.odt;
	assign LINK.cmd = r.cmd;
	assign LINK.bank = r.bank;
	assign LINK.addr = r.addr_o;
	assign LINK.dq_ctl_out = r.dq;
	assign LINK.dq_ctl_oe_n = r.dq_oe_n;
endmodule
`default_nettype wire

// *** inc/ddr2_link_pkg.sv ***
// Shared constants, types and helpers for the DDR2 command link
`default_nettype none
package ddr2_link_pkg;
	localparam int DQ_W = 16;
	localparam int PAIR_W = 2 * DQ_W;
	localparam int BANKS = 8;
	localparam int BANK_W = 3;
	localparam int ADDR_W = 14;
	localparam int DLY = 16;
	localparam int IDX_W = BANK_W + 2;
	localparam int WORDS = 1 << IDX_W;
	localparam int TMR_W = 5;
	localparam int CNT_W = 8;
	typedef enum logic [2:0] {
		CMD_NOP = 3'h0, CMD_ACT = 3'h1, CMD_RD = 3'h2, CMD_WR = 3'h3,
		CMD_PRE = 3'h4, CMD_REF = 3'h5, CMD_MRS = 3'h6, CMD_EMRS = 3'h7
	} cmd_t;
	// Address bits on the link
	localparam int AP_BIT = 10;
	localparam int COL_LSB = 2;
	localparam int MRS_BL_LSB = 0;
	localparam int MRS_CL_LSB = 4;
	localparam int MRS_WR_LSB = 9;
	localparam int EMRS_AL_LSB = 3;
	localparam logic [2:0] BL4_CODE = 3'h2;
	localparam logic [2:0] BL8_CODE = 3'h3;
	localparam logic [2:0] CL_RST = 3'h3;
	localparam logic [2:0] AL_RST = 3'h0;
	localparam logic [2:0] WR_RST = 3'h2;
	localparam logic [2:0] SINCE_SAT = 3'h7;
	// Timing, in picoseconds, half clocks or memory clocks, and derived cycle counts
	localparam int CLK_PS = 10000;
	localparam int WTR_PS = 7500;
	localparam int XSNR_PS = 137500;
	localparam int AOFD_HALF_CK = 5;
	localparam int XSRD_CK = 200;
	localparam int WTR_CYC = (WTR_PS + CLK_PS - 1) / CLK_PS;
	localparam int XSNR_CYC = (XSNR_PS + CLK_PS - 1) / CLK_PS;
	localparam int AOFD_CYC = (AOFD_HALF_CK + 1) / 2;
	localparam int XSRD_CYC = XSRD_CK;
	// Controller register map
	localparam int REG_A_W = 4;
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h1;
	localparam logic [3:0] REG_MODE = 4'h2;
	localparam logic [3:0] REG_CTRL = 4'h3;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_WDATA0 = 4'h8;
	localparam logic [3:0] REG_RDATA0 = 4'hc;
	localparam logic [3:0] SW_SRE = 4'h8;
	localparam logic [3:0] SW_SRX = 4'h9;
	localparam int CMD_BANK_LSB = 4;
	localparam int CMD_AP_BIT = 7;
	localparam int MODE_BL8_BIT = 0;
	localparam int MODE_CL_LSB = 4;
	localparam int MODE_AL_LSB = 8;
	localparam int MODE_WR_LSB = 12;
	localparam int CTRL_ODT_BIT = 0;
	localparam int CTRL_PD_BIT = 1;
	localparam int ST_REFUSED = 0;
	localparam int ST_SR = 1;
	localparam int ST_CKE = 2;
	localparam int ST_ODT = 3;
	localparam int ST_OPEN_LSB = 8;
	function automatic logic [3:0] read_latency(logic [2:0] al,
			logic [2:0] cl);
		return 4'(al) + 4'(cl);
	endfunction
	function automatic logic [3:0] write_latency(logic [2:0] al,
			logic [2:0] cl);
		return read_latency(al, cl) - 4'h1;
	endfunction
	function automatic logic [2:0] half_burst(logic bl8);
		return bl8 ? 3'h4 : 3'h2;
	endfunction
endpackage
`default_nettype wire

// *** inc/ddr2_link_if.sv ***
// Command, clock-enable, termination and data wires between the two ends
`default_nettype none
interface ddr2_link_if;
	import ddr2_link_pkg::*;
	logic cke;
	logic odt;
	cmd_t cmd;
	logic [BANK_W-1:0] bank;
	logic [ADDR_W-1:0] addr;
	logic [PAIR_W-1:0] dq_ctl_out;
	logic dq_ctl_oe_n;
	logic [PAIR_W-1:0] dq_dev_out;
	logic dq_dev_oe_n;
	logic [PAIR_W-1:0] dq;
	// Undriven bus reads as zero
	assign dq = !dq_ctl_oe_n ? dq_ctl_out :
		!dq_dev_oe_n ? dq_dev_out : '0;
	modport ctl (output cke, odt, cmd, bank, addr, dq_ctl_out,
		dq_ctl_oe_n, input dq);
	modport dev (input cke, odt, cmd, bank, addr, dq,
		output dq_dev_out, dq_dev_oe_n);
endinterface
`default_nettype wire

// *** design/ddr2_countdown.sv ***
// Loadable down counter that reports when it has run out
`default_nettype none
module ddr2_countdown #(
	parameter int W = 5
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic load,
	input wire logic [W-1:0] value,
	output logic idle
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} cd_t;
	cd_t r;
	cd_t next_r;
	if (W < 1) begin : g_chk
		$error("counter width must be at least one");
	end
	always_comb begin
		next_r = r;
		if (load) begin
			next_r.cnt = value;
		end else if (r.cnt != '0) begin
			next_r.cnt = r.cnt - 1'b1;
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
	assign idle = (r.cnt == '0);
endmodule
`default_nettype wire

// *** design/ddr2_mem_end.sv ***
// Memory end: command decode, write bursts, array and read bursts
`default_nettype none
module ddr2_mem_end
	import ddr2_link_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic NRST,
	ddr2_link_if.dev LINK,
	output logic [BANKS-1:0] OPEN_BANKS,
	output logic SELF_REFRESH,
	output logic POWER_DOWN,
	output logic BURST8
);
	typedef struct packed {
		logic v;
		logic rd;
		logic [BANK_W-1:0] bank;
		logic [1:0] col;
	} ev_t;
	typedef struct packed {
		logic bl8;
		logic [2:0] cl;
		logic [2:0] al;
		logic [2:0] wr;
		logic cke;
		logic sr;
		logic pd;
		logic [BANKS-1:0] open;
		logic [BANKS-1:0] apq;
		ev_t [DLY-1:0] line;
		logic wact;
		logic [BANK_W-1:0] wbank;
		logic [1:0] wcol;
		logic [1:0] wbeat;
		logic [PAIR_W-1:0] wlow;
		logic [WTR_CYC-1:0] sv;
		logic [WTR_CYC-1:0][IDX_W-1:0] sidx;
		logic [WTR_CYC-1:0][2*PAIR_W-1:0] sdata;
		logic ract;
		logic [BANK_W-1:0] rbank;
		logic [1:0] rcol;
		logic [1:0] rbeat;
		logic [PAIR_W-1:0] dq;
		logic dq_oe_n;
		logic [WORDS-1:0][2*PAIR_W-1:0] mem;
	} dev_t;
	dev_t r;
	dev_t next_r;
	ev_t ev;
	ev_t tap;
	logic take;
	logic [3:0] wl;
	logic [2:0] hb;
	logic [1:0] last;
	logic [1:0] b;
	logic [1:0] rb;
	logic [BANK_W-1:0] rbk;
	logic [1:0] rc;
	logic [2*PAIR_W-1:0] word;
	logic [BANKS-1:0] tload;
	logic [TMR_W-1:0] tval;
	logic [BANKS-1:0] idle;
	for (genvar g = 0; g < BANKS; g++) begin : g_ap
		ddr2_countdown #(.W(TMR_W)) u_ap (
			.clk(CORE_CLK),
			.nrst(NRST),
			.load(tload[g]),
			.value(tval),
			.idle(idle[g])
		);
	end
	always_comb begin
		next_r = r;
		ev = '0;
		tload = '0;
		tval = '0;
		wl = write_latency(r.al, r.cl);
		hb = half_burst(r.bl8);
		last = r.bl8 ? 2'h3 : 2'h1;
		take = LINK.cke && r.cke && !r.sr;
		// Power-down and self refresh freeze only command intake
		next_r.cke = LINK.cke;
		if (r.cke && !LINK.cke && !r.sr && !r.pd) begin
			if (LINK.cmd == CMD_REF) begin
				next_r.sr = 1'b1;
			end else begin
				next_r.pd = 1'b1;
			end
		end
		if (LINK.cke) begin
			next_r.sr = 1'b0;
			next_r.pd = 1'b0;
		end
		if (take) begin
			unique case (LINK.cmd)
				CMD_ACT: next_r.open[LINK.bank] = 1'b1;
				CMD_PRE: begin
					if (LINK.addr[AP_BIT]) begin
						next_r.open = '0;
					end else begin
						next_r.open[LINK.bank] = 1'b0;
					end
				end
				CMD_RD, CMD_WR: begin
					// Any open bank, same or other
					ev.v = 1'b1;
					ev.rd = (LINK.cmd == CMD_RD);
					ev.bank = LINK.bank;
					ev.col = LINK.addr[COL_LSB +: 2];
					if (LINK.addr[AP_BIT]) begin
						tload[LINK.bank] = 1'b1;
						// Counted from programmed burst length
						tval = ev.rd ? 5'(r.al) + 5'(hb) - 5'h1 :
							5'(wl) + 5'(hb) + 5'(r.wr) - 5'h1;
					end
				end
				CMD_MRS: begin
					next_r.bl8 = LINK.addr[MRS_BL_LSB +: 3] == BL8_CODE;
					next_r.cl = LINK.addr[MRS_CL_LSB +: 3];
					next_r.wr = LINK.addr[MRS_WR_LSB +: 3] + 3'h1;
				end
				CMD_EMRS: next_r.al = LINK.addr[EMRS_AL_LSB +: 3];
				CMD_NOP, CMD_REF: ;
			endcase
		end
		next_r.line = {r.line[DLY-2:0], ev};
		for (int i = 0; i < BANKS; i++) begin
			if (tload[i]) begin
				next_r.apq[i] = 1'b1;
			end else if (r.apq[i] && idle[i]) begin
				next_r.apq[i] = 1'b0;
				next_r.open[i] = 1'b0;
			end
		end
		tap = r.line[wl-4'h1];
		// A new write restarts the burst engine
		if (tap.v && !tap.rd) begin
			next_r.wbank = tap.bank;
			next_r.wcol = tap.col;
			b = 2'h0;
		end else begin
			b = r.wbeat;
		end
		next_r.sv[0] = 1'b0;
		next_r.sidx[0] = {r.wbank, r.wcol ^ {1'b0, b[1]}};
		next_r.sdata[0] = {LINK.dq, r.wlow};
		if ((tap.v && !tap.rd) || r.wact) begin
			if (!b[0]) begin
				next_r.wlow = LINK.dq;
			end else begin
				next_r.sv[0] = 1'b1;
			end
			next_r.wbeat = b + 2'h1;
			next_r.wact = (b != last);
		end
		// Prefetch word waits in the input buffer before the array
		for (int i = WTR_CYC - 1; i > 0; i--) begin
			next_r.sv[i] = r.sv[i-1];
			next_r.sidx[i] = r.sidx[i-1];
			next_r.sdata[i] = r.sdata[i-1];
		end
		if (r.sv[WTR_CYC-1]) begin
			next_r.mem[r.sidx[WTR_CYC-1]] = r.sdata[WTR_CYC-1];
		end
		rb = (tap.v && tap.rd) ? 2'h0 : r.rbeat;
		rbk = (tap.v && tap.rd) ? tap.bank : r.rbank;
		rc = (tap.v && tap.rd) ? tap.col : r.rcol;
		word = r.mem[{rbk, rc ^ {1'b0, rb[1]}}];
		next_r.dq_oe_n = 1'b1;
		if ((tap.v && tap.rd) || r.ract) begin
			next_r.rbank = rbk;
			next_r.rcol = rc;
			next_r.dq = rb[0] ? word[PAIR_W +: PAIR_W] : word[PAIR_W-1:0];
			next_r.dq_oe_n = 1'b0;
			next_r.rbeat = rb + 2'h1;
			next_r.ract = (rb != last);
		end
	end
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			r <= '0;
			r.cl <= CL_RST;
			r.al <= AL_RST;
			r.wr <= WR_RST;
			r.dq_oe_n <= 1'b1;
		end else begin
			r <= next_r;
		end
	end
	assign LINK.dq_dev_out = r.dq;
	assign LINK.dq_dev_oe_n = r.dq_oe_n;
	assign OPEN_BANKS = r.open;
	assign SELF_REFRESH = r.sr;
	assign POWER_DOWN = r.pd;
	assign BURST8 = r.bl8;
endmodule
`default_nettype wire

// *** testbench/ddr2_link_props.sv ***
// Timing checker for the command wires between the two ends
`default_nettype none
module ddr2_link_props
	import ddr2_link_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic cke,
	input wire logic odt,
	input wire cmd_t cmd,
	input wire logic [BANK_W-1:0] bank,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic dq_ctl_oe_n,
	input wire logic dq_dev_oe_n
);
	logic bl8, ap_wr, sr;
	logic [2:0] cl, al;
	logic [3:0] wrc, wl, half;
	logic [BANK_W-1:0] bank_wr;
	logic [BANKS-1:0] open_b;
	logic [CNT_W-1:0] since_wr, since_x;
	logic [15:0] wh, rh;
	assign half = bl8 ? 4'h4 : 4'h2;
	assign wl = 4'(al) + 4'(cl) - 4'h1;
	// Mode, open banks, distance from last write and from exit
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			bl8 <= 1'b0;
			cl <= CL_RST;
			al <= AL_RST;
			wrc <= 4'(WR_RST);
			ap_wr <= 1'b0;
			bank_wr <= '0;
			open_b <= '0;
			sr <= 1'b0;
			since_wr <= '1;
			since_x <= '1;
			wh <= '0;
			rh <= '0;
		end else begin
			wh <= {wh[14:0], cmd == CMD_WR};
			rh <= {rh[14:0], cmd == CMD_RD};
			since_wr <= (cmd == CMD_WR) ? 8'h1 :
				since_wr + 8'(since_wr != '1);
			since_x <= (sr && cke) ? 8'h1 : since_x + 8'(since_x != '1);
			if (cmd == CMD_WR) begin
				ap_wr <= addr[AP_BIT];
				bank_wr <= bank;
			end
			if (cmd == CMD_MRS) begin
				bl8 <= addr[2:0] == BL8_CODE;
				cl <= addr[6:4];
				wrc <= 4'(addr[11:9]) + 4'h1;
			end
			if (cmd == CMD_EMRS)
				al <= addr[5:3];
			if (cmd == CMD_REF && !cke)
				sr <= 1'b1;
			else if (sr && cke)
				sr <= 1'b0;
			if (cmd == CMD_ACT)
				open_b[bank] <= 1'b1;
			else if (cmd == CMD_PRE && addr[AP_BIT])
				open_b <= '0;
			else if (cmd == CMD_PRE ||
					(cmd inside {CMD_RD, CMD_WR} && addr[AP_BIT]))
				open_b[bank] <= 1'b0;
		end
	end
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);
	a_rd_gap: assert property ( // Read after write
		cmd == CMD_RD |-> since_wr >= 8'(cl) + 8'(half) + 8'(WTR_CYC) - 8'h1)
		else $error("write to read spacing too short");
	a_wr_spacing: assert property ( // Write spacing
		cmd == CMD_WR |-> since_wr >= 8'(half) ||
			(bl8 && !ap_wr && since_wr == 8'h2))
		else $error("write spacing illegal");
	a_pre_recovery: assert property ( // Precharge after write
		cmd == CMD_PRE && (addr[AP_BIT] || bank == bank_wr) |->
			since_wr >= 8'(wl) + 8'(half) + 8'(wrc))
		else $error("precharge too soon after write");
	a_sr_idle: assert property ( // Banks idle
		cmd == CMD_REF |-> open_b == '0)
		else $error("refresh with an open bank");
	a_odt_entry: assert property ( // Termination off
		cmd == CMD_REF && !cke |-> !odt && !$past(odt) &&
			!$past(odt, 2) && !$past(odt, 3))
		else $error("termination on too close to entry");
	a_odt_exit: assert property ( // Termination back
		odt |-> !sr && since_x >= 8'(XSRD_CYC))
		else $error("termination on too soon after exit");
	a_exit_other: assert property ( // Any command after exit
		cmd != CMD_NOP |-> !sr && since_x >= 8'(XSNR_CYC))
		else $error("command too soon after exit");
	a_exit_read: assert property ( // Read after exit
		cmd == CMD_RD |-> since_x >= 8'(XSRD_CYC))
		else $error("read too soon after exit");
	a_wr_lat: assert property ( // Write data start
		wh[wl - 4'h1] |-> !dq_ctl_oe_n)
		else $error("write data not at write latency");
	a_rd_lat: assert property ( // Read data start
		rh[wl] |-> !dq_dev_oe_n)
		else $error("read data not at read latency");
endmodule
`default_nettype wire

// *** testbench/ddr2_write_burst_command_timing_bench.sv ***
// Bench joining both link ends, driven through the register port
`default_nettype none
module ddr2_write_burst_command_timing_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import ddr2_link_pkg::*;
	logic core_clk, nrst, reg_wr, reg_rd;
	logic [REG_A_W-1:0] reg_addr;
	logic [PAIR_W-1:0] reg_wdata, reg_rdata, rd_val;
	logic [BANKS-1:0] open_banks;
	logic self_refresh, power_down, burst8;
	int errors, cmp_count;
	ddr2_link_if link();
	ddr2_ctl_end u_ddr2_ctl_end(.CORE_CLK(core_clk), .NRST(nrst),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_RDATA(reg_rdata), .LINK(link.ctl));
	ddr2_mem_end u_ddr2_mem_end(.CORE_CLK(core_clk), .NRST(nrst),
		.LINK(link.dev), .OPEN_BANKS(open_banks),
		.SELF_REFRESH(self_refresh), .POWER_DOWN(power_down),
		.BURST8(burst8));
	ddr2_link_props u_ddr2_link_props(.CORE_CLK(core_clk), .NRST(nrst),
		.cke(link.cke), .odt(link.odt), .cmd(link.cmd), .bank(link.bank),
		.addr(link.addr), .dq_ctl_oe_n(link.dq_ctl_oe_n),
		.dq_dev_oe_n(link.dq_dev_oe_n));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("errors=%0d comparisons=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wait_c(input int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_rd <= 1'b0;
		reg_wr <= 1'b1;
		@(posedge core_clk);
	endtask
	task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge core_clk);
	endtask
	task automatic issue(input logic [3:0] code, input logic [2:0] bk,
			input logic ap);
		bus_wr(REG_CMD, {24'h0, ap, bk, code});
	endtask
	// Read the sticky refusal flag, then clear it
	task automatic expect_ref(input logic e);
		bus_rd(REG_STATUS, rd_val);
		check(32'(rd_val[ST_REFUSED]), 32'(e));
		bus_wr(REG_STATUS, 32'h1);
	endtask
	// Write to bank 5, then a second command gap clocks later
	task automatic probe(input int gap, input logic [3:0] code,
			input logic e);
		issue(4'(CMD_WR), 3'h5, 1'b0);
		if (gap > 1)
			wait_c(gap - 1);
		issue(code, 3'h5, 1'b0);
		expect_ref(e);
		wait_c(16);
	endtask
	task automatic pre_all;
		bus_wr(ddr2_link_pkg::REG_ADDR, 32'h400);
		issue(4'(CMD_PRE), 3'h0, 1'b0);
		bus_wr(ddr2_link_pkg::REG_ADDR, 32'h0);
		wait_c(16);
	endtask
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		#200us;
		errors++;
		wrap_up();
	end
	initial begin
		errors = 0;
		cmp_count = 0;
		nrst = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		bus_rd(REG_STATUS, rd_val);
		check(rd_val, 32'h4);
		bus_rd(4'h5, rd_val);
		check(rd_val, 32'h0);
		bus_wr(REG_WDATA0, 32'hc0de_0001);
		bus_wr(REG_WDATA0 + 4'h1, 32'hc0de_0002);
		issue(4'(CMD_ACT), 3'h5, 1'b0);
		issue(4'(CMD_ACT), 3'h2, 1'b0);
		wait_c(2);
		check(32'(open_banks), 32'h24);
		issue(4'(CMD_WR), 3'h5, 1'b0);
		wait_c(1);
		issue(4'(CMD_WR), 3'h2, 1'b0);
		expect_ref(1'b0);
		wait_c(16);
		probe(1, 4'(CMD_WR), 1'b1);
		probe(2, 4'(CMD_WR), 1'b0);
		probe(4, 4'(CMD_RD), 1'b1);
		probe(5, 4'(CMD_RD), 1'b0);
		bus_rd(REG_RDATA0, rd_val);
		check(rd_val, 32'hc0de_0001);
		bus_rd(REG_RDATA0 + 4'h1, rd_val);
		check(rd_val, 32'hc0de_0002);
		probe(5, 4'(CMD_PRE), 1'b1);
		probe(6, 4'(CMD_PRE), 1'b0);
		pre_all();
		bus_wr(REG_MODE, 32'h2031);
		wait_c(2);
		issue(4'(CMD_MRS), 3'h0, 1'b0);
		wait_c(4);
		check(32'(burst8), 32'h1);
		issue(4'(CMD_ACT), 3'h5, 1'b0);
		issue(4'(CMD_ACT), 3'h2, 1'b0);
		wait_c(4);
		probe(2, 4'(CMD_RD), 1'b1);
		probe(2, 4'(CMD_PRE), 1'b1);
		probe(3, 4'(CMD_WR), 1'b1);
		probe(2, 4'(CMD_WR), 1'b0);
		probe(4, 4'(CMD_WR), 1'b0);
		probe(7, 4'(CMD_PRE), 1'b1);
		issue(4'(CMD_WR), 3'h5, 1'b0);
		wait_c(1);
		issue(4'(CMD_WR), 3'h2, 1'b1);
		expect_ref(1'b0);
		wait_c(16);
		issue(4'(CMD_ACT), 3'h2, 1'b0);
		wait_c(4);
		issue(4'(CMD_WR), 3'h5, 1'b1);
		wait_c(1);
		issue(4'(CMD_WR), 3'h2, 1'b0);
		expect_ref(1'b1);
		wait_c(16);
		issue(4'h8, 3'h0, 1'b0);
		expect_ref(1'b1);
		pre_all();
		bus_wr(REG_CTRL, 32'h1);
		wait_c(4);
		bus_wr(REG_CTRL, 32'h0);
		issue(4'h8, 3'h0, 1'b0);
		expect_ref(1'b1);
		wait_c(4);
		issue(4'h8, 3'h0, 1'b0);
		expect_ref(1'b0);
		wait_c(2);
		check(32'({self_refresh, link.cke}), 32'h2);
		issue(4'(CMD_ACT), 3'h1, 1'b0);
		expect_ref(1'b1);
		issue(4'h9, 3'h0, 1'b0);
		issue(4'(CMD_ACT), 3'h1, 1'b0);
		expect_ref(1'b1);
		wait_c(16);
		check(32'(self_refresh), 32'h0);
		issue(4'(CMD_ACT), 3'h1, 1'b0);
		expect_ref(1'b0);
		issue(4'(CMD_RD), 3'h1, 1'b0);
		expect_ref(1'b1);
		wait_c(200);
		issue(4'(CMD_RD), 3'h1, 1'b0);
		expect_ref(1'b0);
		wait_c(16);
		bus_wr(REG_CTRL, 32'h1);
		wait_c(2);
		for (int i = 0; i < 4; i++) begin
			bus_wr(REG_CTRL, 32'h2);
			wait_c(3);
			check(32'(power_down), 32'h1);
			bus_wr(REG_CTRL, 32'h0);
			wait_c(3);
		end
		issue(4'(CMD_PRE), 3'h1, 1'b0);
		expect_ref(1'b0);
		wait_c(16);
		check(32'(open_banks), 32'h0);
		wrap_up();
	end
endmodule
`default_nettype wire
